// ---- src/eep_map.vh ----
// constants of the two-wire serial memory target
// Function
// - sample data on rising clock edge, shift output data on falling clock edge
// - data pin is open drain: pull low or release, never drive high
// - three address straps select one of 8 targets, unconnected strap reads zero
// - write-inhibit high blocks every array write, low lets writes proceed
// - array holds 256 bytes as 32 pages of 8, 8-bit word address
// - data falling while clock high is a start, start precedes every command
// - data rising while clock high is a stop, stop after read gives standby
// - transfers are 8-bit words, target pulls data low in ninth clock
// - standby after power-up, after stop in read, after programming ends
// - first byte: bits 7-4 are 1010, bits 3-1 straps, bit 0 read/write
// - address bit 0 high starts read, low starts write
// - matching address acknowledged; mismatch not acknowledged, standby until next start
// - byte write: address, word address, one data byte acked; stop starts programming
// - during programming all bus inputs ignored; cycle completes within 5 ms
// - page write: further data bytes each acknowledged, ended by stop
// - only low three address bits increment on writes, wrapping inside page
// - polling address gets acknowledge only after programming finished
// - address counter holds last address plus one, reads wrap to zero
// - current read: after read address ack, shift out byte at counter
// - random read: dummy write of word address, repeated start, read address
// - controller ack on read byte advances address and sends next byte
`ifndef EEP_MAP_VH
`define EEP_MAP_VH

`define EEP_DEV_CODE     4'hA
`define EEP_LAST_BIT     4'h7
`define EEP_ACK_BIT      4'h8
`define EEP_PRE_BIT      4'hF
`define EEP_PAGE_BITS    3
`define EEP_ADDR_BITS    8
`define EEP_CLK_HZ       20000000
`define EEP_TWR_MS       5
`define EEP_TWR_CYC      ((`EEP_TWR_MS * `EEP_CLK_HZ) / 1000)
`define EEP_COMMIT_CYC   8

`endif

// ---- src/eep_fifo.v ----
// small valid/ready buffer between byte receiver and page staging
`timescale 1ns/1ps
module eep_fifo #(
    parameter W  = 16,
    parameter AW = 1
) (
    // clock and reset
    input  wire         clk_i,
    input  wire         srst_i,
    // fill side
    input  wire         in_valid_i,
    output wire         in_ready_o,
    input  wire [W-1:0] in_data_i,
    // drain side
    output wire         out_valid_o,
    input  wire         out_ready_i,
    output wire [W-1:0] out_data_o
);
    localparam DEPTH = 1 << AW;

    reg [W-1:0]  mem [0:DEPTH-1];
    reg [AW-1:0] wptr;
    reg [AW-1:0] rptr;
    reg [AW:0]   count;

    wire do_push = in_valid_i & in_ready_o;
    wire do_pop  = out_valid_o & out_ready_i;

    assign in_ready_o  = (count != DEPTH[AW:0]);
    assign out_valid_o = (count != {(AW+1){1'b0}});
    assign out_data_o  = mem[rptr];

    always @(posedge clk_i) begin
        if (do_push) begin
            mem[wptr] <= in_data_i;
        end
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            wptr  <= {AW{1'b0}};
            rptr  <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (do_push) begin
                wptr <= wptr + 1'b1;
            end
            if (do_pop) begin
                rptr <= rptr + 1'b1;
            end
            if (do_push && !do_pop) begin
                count <= count + 1'b1;
            end else if (do_pop && !do_push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // eep_fifo

// ---- src/eep_core.v ----
// two-wire serial memory target with 256-byte array and timed page programming
`timescale 1ns/1ps
`include "eep_map.vh"
module eep_core #(
    parameter PROG_CYCLES = `EEP_TWR_CYC,
    parameter TMR_W       = 17,
    parameter FIFO_AW     = 1
) (
    // clock and reset
    input  wire       clk_i,
    input  wire       srst_i,
    // two-wire bus
    input  wire       scl_i,
    input  wire       sda_i,
    output reg        sda_o,
    output reg        sda_oe_o,
    // straps
    input  wire [2:0] bus_address_straps_i,
    input  wire       write_inhibit_i,
    // status
    output reg        busy_o,
    output reg        standby_o
);
    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    localparam [5:0] ST_IDLE  = 6'h01;
    localparam [5:0] ST_DEV   = 6'h02;
    localparam [5:0] ST_WADDR = 6'h04;
    localparam [5:0] ST_WDATA = 6'h08;
    localparam [5:0] ST_RDATA = 6'h10;
    localparam [5:0] ST_PROG  = 6'h20;

    localparam integer     PROG_END_N = PROG_CYCLES - `EEP_COMMIT_CYC;
    localparam [TMR_W-1:0] PROG_END   = PROG_END_N[TMR_W-1:0];
    localparam NSYNC = 5;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    wire [NSYNC-1:0] raw_in = {write_inhibit_i, bus_address_straps_i, sda_i};
    reg  [NSYNC-1:0] sync1;
    reg  [NSYNC-1:0] sync2;
    reg              scl_s1;
    reg              scl_s2;
    reg              scl_d;
    reg              sda_d;

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            always @(posedge clk_i) begin
                if (srst_i) begin
                    sync1[gi] <= (gi == 0) ? 1'b1 : 1'b0;
                    sync2[gi] <= (gi == 0) ? 1'b1 : 1'b0;
                end else begin
                    sync1[gi] <= raw_in[gi];
                    sync2[gi] <= sync1[gi];
                end
            end
        end
    endgenerate

    // clock chain as deep as the data chain, so start and stop compare aligned levels
    always @(posedge clk_i) begin
        if (srst_i) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_d  <= 1'b1;
            sda_d  <= 1'b1;
        end else begin
            scl_s1 <= scl_i;
            scl_s2 <= scl_s1;
            scl_d  <= scl_s2;
            sda_d  <= sync2[0];
        end
    end

    wire       sda_s    = sync2[0];
    wire [2:0] straps   = sync2[3:1];
    wire       inhibit  = sync2[4];
    wire       scl_rise = scl_s2 & ~scl_d;
    wire       scl_fall = ~scl_s2 & scl_d;
    wire       start_c  = scl_d & scl_s2 & sda_d & ~sda_s;
    wire       stop_c   = scl_d & scl_s2 & ~sda_d & sda_s;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    reg [7:0] mem   [0:(1 << `EEP_ADDR_BITS)-1];
    reg [7:0] stage [0:(1 << `EEP_PAGE_BITS)-1];

    reg [5:0]                 state;
    reg [3:0]                 bitcnt;
    reg [7:0]                 sreg;
    reg [7:0]                 tx;
    reg [7:0]                 addr;
    reg                       rw;
    reg                       mack;
    reg                       wrote;
    reg                       push;
    reg [7:0]                 mask;
    reg [4:0]                 row;
    reg [TMR_W-1:0]           tmr;
    reg [`EEP_PAGE_BITS-1:0]  ci;

    wire        st_prog = (state == ST_PROG);
    wire        in_ready;
    wire        out_valid;
    wire [15:0] out_data;
    wire        drain   = out_valid & ~st_prog;
    wire        dev_hit = (sreg[7:4] == `EEP_DEV_CODE) && (sreg[3:1] == straps);
    wire        commit  = st_prog && (tmr == PROG_END);
    wire        mem_we  = commit && mask[ci];

    // ------------------------------------------------------------
    // write buffer
    // ------------------------------------------------------------
    // received bytes wait here while the page is being staged
    eep_fifo #(
        .W  (16),
        .AW (FIFO_AW)
    ) u_fifo (
        .clk_i       (clk_i),
        .srst_i      (srst_i),
        .in_valid_i  (push),
        .in_ready_o  (in_ready),
        .in_data_i   ({addr, sreg}),
        .out_valid_o (out_valid),
        .out_ready_i (~st_prog),
        .out_data_o  (out_data)
    );

    always @(posedge clk_i) begin
        if (drain) begin
            stage[out_data[10:8]] <= out_data[7:0];
        end
    end

    always @(posedge clk_i) begin
        if (mem_we) begin
            mem[{row, ci}] <= stage[ci];
        end
    end

    // ------------------------------------------------------------
    // programming timer
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        if (srst_i || !st_prog) begin
            tmr <= {TMR_W{1'b0}};
            ci  <= {`EEP_PAGE_BITS{1'b0}};
        end else if (!commit) begin
            tmr <= tmr + 1'b1;
        end else begin
            // last cycles of the timer copy the staged page into the array
            ci <= ci + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        if (srst_i) begin
            sda_o     <= 1'b0;
            busy_o    <= 1'b0;
            standby_o <= 1'b1;
        end else begin
            // both flags lag the state by one clock
            sda_o     <= 1'b0;
            busy_o    <= st_prog;
            standby_o <= (state == ST_IDLE);
        end
    end

    // ------------------------------------------------------------
    // protocol engine
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        if (srst_i) begin
            state     <= ST_IDLE;
            bitcnt    <= 4'h0;
            sreg      <= 8'h00;
            tx        <= 8'h00;
            addr      <= 8'h00;
            rw        <= 1'b0;
            mack      <= 1'b0;
            wrote     <= 1'b0;
            push      <= 1'b0;
            mask      <= 8'h00;
            row       <= 5'h00;
            sda_oe_o  <= 1'b0;
        end else begin
            push      <= 1'b0;
            if (drain) begin
                mask[out_data[10:8]] <= 1'b1;
                row                  <= out_data[15:11];
            end
            if (st_prog) begin
                // bus ignored while programming, polls get no acknowledge
                sda_oe_o <= 1'b0;
                if (commit && ci == {`EEP_PAGE_BITS{1'b1}}) begin
                    state <= ST_IDLE;
                    mask  <= 8'h00;
                    wrote <= 1'b0;
                end
            end else if (start_c) begin
                // one below zero, so the clock fall that closes the start is not counted
                state    <= ST_DEV;
                bitcnt   <= `EEP_PRE_BIT;
                sda_oe_o <= 1'b0;
                mask     <= 8'h00;
                wrote    <= 1'b0;
            end else if (stop_c) begin
                sda_oe_o <= 1'b0;
                bitcnt   <= 4'h0;
                if (state == ST_WDATA && wrote && !inhibit) begin
                    state <= ST_PROG;
                end else begin
                    state <= ST_IDLE;
                end
            end else if (scl_rise) begin
                if (state == ST_RDATA) begin
                    if (bitcnt == `EEP_ACK_BIT) begin
                        mack <= ~sda_s;
                    end
                end else if (bitcnt != `EEP_ACK_BIT) begin
                    sreg <= {sreg[6:0], sda_s};
                end
            end else if (scl_fall) begin
                case (state)
                    ST_DEV, ST_WADDR, ST_WDATA: begin
                        if (bitcnt == `EEP_LAST_BIT) begin
                            bitcnt <= `EEP_ACK_BIT;
                            if (state == ST_DEV) begin
                                if (dev_hit) begin
                                    sda_oe_o <= 1'b1;
                                    rw       <= sreg[0];
                                end else begin
                                    // foreign address: stay quiet until the next start
                                    state <= ST_IDLE;
                                end
                            end else if (state == ST_WADDR) begin
                                sda_oe_o <= 1'b1;
                            end else if (in_ready) begin
                                sda_oe_o <= 1'b1;
                                push     <= ~inhibit;
                                wrote    <= wrote | ~inhibit;
                            end
                        end else if (bitcnt == `EEP_ACK_BIT) begin
                            sda_oe_o <= 1'b0;
                            bitcnt   <= 4'h0;
                            if (state == ST_DEV) begin
                                if (rw) begin
                                    state    <= ST_RDATA;
                                    tx       <= mem[addr];
                                    sda_oe_o <= ~mem[addr][7];
                                    addr     <= addr + 1'b1;
                                end else begin
                                    state <= ST_WADDR;
                                end
                            end else if (state == ST_WADDR) begin
                                addr  <= sreg;
                                state <= ST_WDATA;
                            // only an acknowledged data byte advances the in-page address
                            end else if (sda_oe_o) begin
                                addr[2:0] <= addr[2:0] + 1'b1;
                            end
                        end else begin
                            bitcnt <= bitcnt + 1'b1;
                        end
                    end
                    ST_RDATA: begin
                        if (bitcnt == `EEP_LAST_BIT) begin
                            sda_oe_o <= 1'b0;
                            bitcnt   <= `EEP_ACK_BIT;
                        end else if (bitcnt == `EEP_ACK_BIT) begin
                            bitcnt <= 4'h0;
                            if (mack) begin
                                tx       <= mem[addr];
                                sda_oe_o <= ~mem[addr][7];
                                addr     <= addr + 1'b1;
                            end else begin
                                // controller nack ends the read ahead of its stop
                                state <= ST_IDLE;
                            end
                        end else begin
                            bitcnt   <= bitcnt + 1'b1;
                            sda_oe_o <= ~tx[6];
                            tx       <= {tx[6:0], 1'b0};
                        end
                    end
                    default: begin
                        bitcnt <= bitcnt;
                    end
                endcase
            end
        end
    end
endmodule // eep_core

// ---- bench/eep_ctl_model.sv ----
// two-wire bus controller model driving the memory target
`timescale 1ns/1ps
module eep_ctl_model (
    // clock
    input  wire logic clk_i,
    // bus
    input  wire logic sda_i,
    output logic      scl_o = 1'b1,
    output logic      sda_pull_o = 1'b0
);
    // ---------------------------------------------
    // bus phases, 8 clocks to one bit cycle, 12 to a start or a stop
    // ---------------------------------------------
    task automatic clk_bit(input logic v, output logic s);
        @(posedge clk_i) sda_pull_o <= ~v;
        repeat (3) @(posedge clk_i);
        scl_o <= 1'b1;
        repeat (2) @(posedge clk_i);
        s = sda_i;
        repeat (2) @(posedge clk_i);
        scl_o <= 1'b0;
    endtask
    task automatic start();
        @(posedge clk_i) sda_pull_o <= 1'b0;
        repeat (3) @(posedge clk_i);
        scl_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        sda_pull_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        scl_o <= 1'b0;
    endtask
    task automatic stop();
        @(posedge clk_i) sda_pull_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        scl_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        sda_pull_o <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic recover();
        logic s;
        for (int i = 0; i < 9; i++) begin
            clk_bit(1'b1, s);
            if (s === 1'b1) break;
        end
        start();
        stop();
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
        clk_bit(1'b1, s);
        ack = ~s;
    endtask
    task automatic rbyte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
        clk_bit(~ack, s);
    endtask
endmodule // eep_ctl_model

// ---- bench/eep_core_sva.sv ----
// assertions on the memory target ports
`timescale 1ns/1ps
module eep_core_sva #(
    parameter PROG_CYCLES = 64
) (
    input wire       clk_i,
    input wire       srst_i,
    input wire       scl_i,
    input wire       sda_i,
    input wire       sda_o,
    input wire       sda_oe_o,
    input wire [2:0] bus_address_straps_i,
    input wire       write_inhibit_i,
    input wire       busy_o,
    input wire       standby_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    int busy_cnt;
    always @(posedge clk_i) busy_cnt <= (srst_i || !busy_o) ? 0 : busy_cnt + 1;
    // ---------------------------------------------
    // sequences
    // ---------------------------------------------
    sequence s_ack_rise;
        $rose(scl_i) && sda_oe_o;
    endsequence
    sequence s_hold;
        sda_oe_o [*3];
    endsequence
    a_sda_never_high: assert property (sda_o == 1'b0)
        else $error("data pin driven high");
    a_reset_idle: assert property ($fell(srst_i) |-> !sda_oe_o && !busy_o && standby_o)
        else $error("wrong state after reset");
    a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !$past(scl_i, 2))
        else $error("data output changed while bus clock high");
    a_hold_in_high: assert property (s_ack_rise |-> s_hold)
        else $error("pull released during clock high");
    a_busy_no_ack: assert property (busy_o |-> !sda_oe_o)
        else $error("bus answered while programming");
    a_busy_max_len: assert property (busy_o |-> busy_cnt < PROG_CYCLES + 2)
        else $error("programming too long");
    a_busy_min_len: assert property ($fell(busy_o) |-> busy_cnt >= PROG_CYCLES - 2)
        else $error("programming too short");
    a_busy_then_idle: assert property ($fell(busy_o) |-> ##[0:2] standby_o)
        else $error("no standby after programming");
    a_standby_quiet: assert property (standby_o |-> !sda_oe_o && !busy_o)
        else $error("standby while active");
endmodule // eep_core_sva
bind eep_core eep_core_sva #(.PROG_CYCLES(PROG_CYCLES)) eep_core_sva_i (
    .clk_i(clk_i), .srst_i(srst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .bus_address_straps_i(bus_address_straps_i),
    .write_inhibit_i(write_inhibit_i), .busy_o(busy_o), .standby_o(standby_o));

// ---- bench/i2c_serial_eeprom_2kbit_tb.sv ----
// testbench of the memory target against a controller model
`timescale 1ns/1ps
module i2c_serial_eeprom_2kbit_tb;
    localparam logic [7:0] AW = 8'hAA;
    logic       clk_i = 1'b0;
    logic       srst_i = 1'b1;
    logic [2:0] straps = 3'h5;
    logic       wi = 1'b0;
    logic       scl, pull, sda_o, sda_oe_o, busy_o, standby_o;
    wire        sda = ~(sda_oe_o | pull);
    int         failures = 0;
    int         n_tests = 0;
    initial forever #25 clk_i = ~clk_i;
    eep_core #(.PROG_CYCLES(64), .TMR_W(17), .FIFO_AW(1)) eep_core_i (
        .clk_i(clk_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_o(sda_oe_o), .bus_address_straps_i(straps), .write_inhibit_i(wi),
        .busy_o(busy_o), .standby_o(standby_o));
    eep_ctl_model eep_ctl_model_i (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
    // ---------------------------------------------
    // helpers
    // ---------------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    function automatic logic [7:0] page_exp(input int k);
        int i = (k + 5) & 7;
        return 8'hA0 + i + (i <= 1 ? 8 : 0);
    endfunction
    task automatic wr(input logic [7:0] wa, input logic [7:0] d0, input int n);
        logic a;
        eep_ctl_model_i.start();
        eep_ctl_model_i.wbyte(AW, a);
        check("write address ack", {7'h00, a}, 8'h01);
        eep_ctl_model_i.wbyte(wa, a);
        check("word address ack", {7'h00, a}, 8'h01);
        for (int i = 0; i < n; i++) begin
            eep_ctl_model_i.wbyte(d0 + i, a);
            check("data ack", {7'h00, a}, 8'h01);
        end
        eep_ctl_model_i.stop();
    endtask
    task automatic poll_wait(input logic first_nack);
        logic a = 1'b0;
        int n = 0;
        while (!a && n < 30) begin
            eep_ctl_model_i.start();
            eep_ctl_model_i.wbyte(AW, a);
            eep_ctl_model_i.stop();
            if (n == 0 && first_nack) check("poll while busy", {7'h00, a}, 8'h00);
            n++;
        end
        check("poll done", {7'h00, a}, 8'h01);
        if (!a) report_and_stop();
    endtask
    task automatic rd_rand(input logic [7:0] wa);
        logic a;
        eep_ctl_model_i.start();
        eep_ctl_model_i.wbyte(AW, a);
        eep_ctl_model_i.wbyte(wa, a);
        eep_ctl_model_i.start();
        eep_ctl_model_i.wbyte(AW | 8'h01, a);
        check("read address ack", {7'h00, a}, 8'h01);
    endtask
    // ---------------------------------------------
    // scenarios
    // ---------------------------------------------
    task automatic t_mismatch();
        logic a;
        eep_ctl_model_i.start();
        eep_ctl_model_i.wbyte(8'hA4, a);
        check("foreign address", {7'h00, a}, 8'h00);
        eep_ctl_model_i.stop();
    endtask
    task automatic t_page_read();
        logic [7:0] b;
        wr(8'h13, 8'hA0, 10);
        poll_wait(1'b1);
        rd_rand(8'h10);
        for (int k = 0; k < 7; k++) begin
            eep_ctl_model_i.rbyte(k < 6, b);
            check("sequential byte", b, page_exp(k));
        end
        eep_ctl_model_i.stop();
        eep_ctl_model_i.start();
        eep_ctl_model_i.wbyte(AW | 8'h01, b[0]);
        eep_ctl_model_i.rbyte(1'b0, b);
        check("current address byte", b, page_exp(7));
        eep_ctl_model_i.stop();
    endtask
    task automatic t_inhibit();
        logic [7:0] b;
        @(posedge clk_i) wi <= 1'b1;
        wr(8'h12, 8'h55, 1);
        repeat (10) @(posedge clk_i);
        check("no programming when inhibited", {7'h00, busy_o}, 8'h00);
        @(posedge clk_i) wi <= 1'b0;
        rd_rand(8'h12);
        eep_ctl_model_i.rbyte(1'b0, b);
        check("inhibited byte kept", b, page_exp(2));
        eep_ctl_model_i.stop();
    endtask
    task automatic t_wrap();
        logic [7:0] b;
        wr(8'hFF, 8'h3C, 1);
        poll_wait(1'b1);
        wr(8'h00, 8'hC3, 1);
        poll_wait(1'b0);
        rd_rand(8'hFF);
        eep_ctl_model_i.rbyte(1'b1, b);
        check("last byte", b, 8'h3C);
        eep_ctl_model_i.rbyte(1'b0, b);
        check("wrapped byte", b, 8'hC3);
        eep_ctl_model_i.stop();
        repeat (4) @(posedge clk_i);
        check("standby after read", {7'h00, standby_o}, 8'h01);
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        srst_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        check("standby after reset", {6'h00, busy_o, standby_o}, 8'h01);
        eep_ctl_model_i.recover();
        t_mismatch();
        t_page_read();
        t_inhibit();
        t_wrap();
        report_and_stop();
    end
endmodule // i2c_serial_eeprom_2kbit_tb
